/* bench/ccm_keystream_encrypt_tb.sv */
// Self-checking bench of the CCM key-stream engine
`timescale 1ns/10ps
module ccm_keystream_encrypt_tb;
	localparam logic [31:0] CFG = 32'h0, TMP = 32'h100, PIN = 32'h600, POUT = 32'h700;
	logic clk, sys_rst, reg_wr, reg_rd, irq, mem_rd, mem_wr, mem_ack;
	logic [7:0] reg_addr, mem_wdata, mem_rdata;
	logic [31:0] reg_wdata, reg_rdata, mem_addr, v;
	logic [3:0] lat;
	int n_mismatch, checked, n_tw, n_ow, n_cr;
	ccmks_top dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
		.mem_addr, .mem_wdata, .mem_rd, .mem_wr, .mem_rdata, .mem_ack);
	ccmks_mem mem_m (.clk, .sys_rst, .mem_addr, .mem_wdata, .mem_rd, .mem_wr, .mem_rdata,
		.mem_ack, .lat);
	always @(posedge clk) begin
		if (mem_ack && mem_wr && mem_addr >= TMP && mem_addr < PIN) n_tw++;
		if (mem_ack && mem_wr && mem_addr >= POUT) n_ow++;
		if (mem_ack && mem_rd && mem_addr < TMP) n_cr++;
	end
	////////////////////////////////////////
	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		// Mid-cycle sample while the read data stand
		@(negedge clk);
		d = reg_rdata;
	endtask : rd
	task automatic wait_ev(input int b);
		v = 32'h0;
		for (int i = 0; i < 3000 && v[b] !== 1'b1; i++) rd(8'h04, v);
		if (v[b] !== 1'b1) begin
			n_mismatch++;
			$display("MISMATCH at %0t: event %0d never came", $time, b);
			print_verdict();
		end
	endtask : wait_ev
	// Quiet gap first so the checker can tell the engine is idle
	task automatic go(input logic [31:0] t);
		repeat (40) @(posedge clk);
		wr(8'h00, t);
	endtask : go
	function automatic int ks_bytes(input int len);
		return 16 * ((len + 15) / 16 + 1);
	endfunction : ks_bytes
	////////////////////////////////////////
	task automatic t_reset;
		logic [7:0] ad [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20, 8'h24, 8'h28, 8'h30};
		for (int i = 0; i < 8; i++) begin
			rd(ad[i], v);
			chk(v, ad[i] == 8'h20 ? 32'hFB : 32'h0, "reset value");
		end
	endtask : t_reset
	task automatic t_keystream_gen_task(input logic [2:0] mode, input logic [7:0] maxpl, input int exp_tw);
		wr(8'h0C, {29'h0, mode});
		wr(8'h20, {24'h0, maxpl});
		n_tw = 0;
		n_cr = 0;
		go(32'h1);
		wait_ev(0);
		chk(n_tw, exp_tw, "key-stream bytes");
		chk(n_cr, 33, "config bytes read");
		chk(irq, 1'b0, "masked event");
		wr(8'h04, 32'h1);
	endtask : t_keystream_gen_task
	task automatic fill_pkt(input logic [7:0] lfield, input int n);
		mem_m.ram[PIN] = 8'h1E;
		mem_m.ram[PIN + 1] = lfield;
		mem_m.ram[PIN + 2] = 8'h00;
		for (int p = 0; p < n; p++) mem_m.ram[PIN + 3 + p] = 8'hC3 + 8'(p);
		n_ow = 0;
	endtask : fill_pkt
	task automatic t_cipher_run_task(input logic [2:0] mode, input logic [7:0] lfield,
		input logic [7:0] lexp, input int n);
		t_keystream_gen_task(mode, 8'hFB, ks_bytes(27));
		// Own key-stream pattern proves the stored one is what gets used
		for (int p = 0; p < 32; p++) mem_m.ram[TMP + 16 + p] = 8'h5A ^ 8'(p);
		fill_pkt(lfield, n);
		go(32'h2);
		rd(8'h28, v);
		chk(v, 32'h1, "busy while running");
		wait_ev(1);
		chk(v, 32'h2, "cipher event");
		rd(8'h04, v);
		chk(v, 32'h2, "event stays set");
		chk(irq, 1'b1, "irq raised");
		chk(mem_m.ram[POUT], 8'h1E, "header");
		chk(mem_m.ram[POUT + 1], lexp, "length field");
		for (int p = 0; p < n; p++)
			chk(mem_m.ram[POUT + 3 + p], (8'hC3 + 8'(p)) ^ (8'h5A ^ 8'(p)), "payload");
		chk(n_ow, n == 0 ? 3 : n + 7, "bytes written");
		wr(8'h04, 32'h2);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0, "irq cleared");
	endtask : t_cipher_run_task
	task automatic t_short;
		fill_pkt(8'h05, 5);
		wr(8'h24, 32'h1);
		t_keystream_gen_task(3'h0, 8'hFB, ks_bytes(27));
		wait_ev(1);
		chk(mem_m.ram[POUT + 1], 8'h09, "shortcut length");
		chk(n_ow, 12, "shortcut bytes");
		wr(8'h04, 32'h3);
		wr(8'h24, 32'h0);
	endtask : t_short
	task automatic t_decrypt;
		wr(8'h0C, 32'h1);
		n_ow = 0;
		go(32'h2);
		repeat (100) @(posedge clk);
		rd(8'h04, v);
		chk(v, 32'h0, "decrypt refused");
		chk(n_ow, 0, "no output in decrypt");
		wr(8'h0C, 32'h0);
	endtask : t_decrypt
	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		lat = 4'h0;
		for (int i = 0; i < 2048; i++) mem_m.ram[i] = 8'(i) ^ 8'h3C;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		wr(8'h10, CFG);
		wr(8'h14, TMP);
		wr(8'h18, PIN);
		wr(8'h1C, POUT);
		wr(8'h08, 32'h2);
		rd(8'h14, v);
		chk(v, TMP, "pointer readback");
		t_keystream_gen_task(3'h2, 8'h21, ks_bytes(33));
		lat <= 4'h3;
		t_keystream_gen_task(3'h2, 8'hFF, ks_bytes(251));
		t_cipher_run_task(3'h4, 8'h1B, 8'h1F, 27);
		lat <= 4'h0;
		t_cipher_run_task(3'h0, 8'hE3, 8'hE7, 3);
		lat <= 4'h1;
		t_cipher_run_task(3'h4, 8'h00, 8'h00, 0);
		t_short();
		t_decrypt();
		print_verdict();
	end
endmodule : ccm_keystream_encrypt_tb

/* bench/ccmks_mem.sv */
// Byte memory answering the engine's memory master port
`timescale 1ns/10ps
module ccmks_mem (
	input logic clk,
	input logic sys_rst,
	input logic [31:0] mem_addr,
	input logic [7:0] mem_wdata,
	input logic mem_rd,
	input logic mem_wr,
	output logic [7:0] mem_rdata,
	output logic mem_ack,
	input logic [3:0] lat
);
	////////////////////////////////////////
	logic [7:0] ram [0:2047];
	logic [3:0] cnt_q;
	logic [7:0] last_q;
	// Plain always: the bench also preloads this array directly
	always @(posedge clk) begin
		if (sys_rst) begin
			mem_ack <= 1'b0;
			cnt_q <= 4'h0;
			last_q <= 8'h00;
		end else if (mem_ack) begin
			mem_ack <= 1'b0;
			cnt_q <= 4'h0;
			last_q <= mem_rdata;
			if (mem_wr) ram[mem_addr[10:0]] <= mem_wdata;
		end else if ((mem_rd || mem_wr) && cnt_q >= lat) begin
			mem_ack <= 1'b1;
		end else if (mem_rd || mem_wr) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
	// Outside an answer the bus shows the inverse, so a stale sample shows up
	assign mem_rdata = (mem_ack && mem_rd) ? ram[mem_addr[10:0]] : ~last_q;
endmodule : ccmks_mem

/* bench/ccmks_top_chk.sv */
// Port checker of the CCM key-stream engine
`timescale 1ns/10ps
module ccmks_top_chk (
	input logic clk,
	input logic sys_rst,
	input logic [7:0] reg_addr,
	input logic [31:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	input logic [31:0] reg_rdata,
	input logic irq,
	input logic [31:0] mem_addr,
	input logic [7:0] mem_wdata,
	input logic mem_rd,
	input logic mem_wr,
	input logic [7:0] mem_rdata,
	input logic mem_ack
);
	////////////////////////////////////////
	logic [1:0] mask_sh;
	logic [2:0] mode_sh;
	logic [31:0] cfg_sh;
	logic [31:0] in_sh;
	logic [5:0] idle_cnt;
	logic task_wr;
	// Long memory silence stands in for the hidden idle state
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mask_sh <= 2'h0;
			mode_sh <= 3'h0;
			cfg_sh <= 32'h0;
			in_sh <= 32'h0;
			idle_cnt <= 6'h0;
		end else begin
			if (reg_wr && reg_addr == 8'h08) mask_sh <= reg_wdata[1:0];
			if (reg_wr && reg_addr == 8'h0C) mode_sh <= reg_wdata[2:0];
			if (reg_wr && reg_addr == 8'h10) cfg_sh <= reg_wdata;
			if (reg_wr && reg_addr == 8'h18) in_sh <= reg_wdata;
			if (mem_rd || mem_wr) idle_cnt <= 6'h0;
			else if (idle_cnt != 6'h3F) idle_cnt <= idle_cnt + 6'h1;
		end
	end
	assign task_wr = reg_wr && reg_addr == 8'h00 && idle_cnt > 6'h1F;
	////////////////////////////////////////
	a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
		!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside read");
	a_rdata_void: assert property (@(posedge clk) disable iff (sys_rst)
		$past(reg_rd) && ($past(reg_addr) == 8'h00 || $past(reg_addr) > 8'h28)
		|-> reg_rdata == 32'h0) else $error("task or unmapped read not zero");
	a_irq_masked: assert property (@(posedge clk) disable iff (sys_rst)
		mask_sh == 2'h0 && $past(mask_sh) == 2'h0 |-> !irq) else $error("irq while masked");
	a_mem_excl: assert property (@(posedge clk) disable iff (sys_rst)
		!(mem_rd && mem_wr)) else $error("read and write at once");
	a_mem_hold: assert property (@(posedge clk) disable iff (sys_rst)
		(mem_rd || mem_wr) && !mem_ack |=> $stable(mem_addr) && $stable({mem_rd, mem_wr}))
		else $error("request changed before answer");
	a_wdata_hold: assert property (@(posedge clk) disable iff (sys_rst)
		mem_wr && !mem_ack |=> $stable(mem_wdata)) else $error("write byte changed");
	a_mem_gap: assert property (@(posedge clk) disable iff (sys_rst)
		mem_ack |=> !mem_rd && !mem_wr) else $error("request not dropped");
	a_ks_cfg_rd: assert property (@(posedge clk) disable iff (sys_rst)
		task_wr && reg_wdata[0] |-> ##[1:6] (mem_rd && mem_addr == cfg_sh))
		else $error("key-stream task did not fetch config");
	a_cr_in_rd: assert property (@(posedge clk) disable iff (sys_rst)
		task_wr && reg_wdata[1] && !mode_sh[0] |-> ##[1:6] (mem_rd && mem_addr == in_sh))
		else $error("cipher task did not fetch packet");
	a_dec_refused: assert property (@(posedge clk) disable iff (sys_rst)
		task_wr && reg_wdata[1] && mode_sh[0] |=> !(mem_rd || mem_wr) [*8])
		else $error("cipher ran in decrypt mode");
endmodule : ccmks_top_chk
bind ccmks_top ccmks_top_chk chk (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .irq, .mem_addr, .mem_wdata, .mem_rd, .mem_wr, .mem_rdata, .mem_ack);

/* rtl/ccmks_aes.sv */
// Iterative AES-128 encryption core, one round per clock
`timescale 1ns/10ps
`include "ccmks_defs.svh"
module ccmks_aes (
	input logic clk,
	input logic sys_rst,
	ccmks_aes_if.core aes
);
	function automatic logic [7:0] ccmks_gmul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) p = p ^ x;
			x = {x[6:0], 1'b0} ^ (x[7] ? 8'h1B : 8'h00);
		end
		return p;
	endfunction : ccmks_gmul

	// Inverse as x^254 keeps the table out of the source
	function automatic logic [7:0] ccmks_sbox(input logic [7:0] a);
		logic [7:0] p;
		logic [7:0] r;
		p = a;
		r = 8'h01;
		for (int i = 1; i < 8; i++) begin
			p = ccmks_gmul(p, p);
			r = ccmks_gmul(r, p);
		end
		return r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]} ^ {r[3:0], r[7:4]} ^ 8'h63;
	endfunction : ccmks_sbox

	function automatic ccmks_pkg::ccmks_blk_t ccmks_round(input ccmks_pkg::ccmks_blk_t s,
		input logic last);
		logic [7:0] b [16];
		logic [7:0] t [16];
		ccmks_pkg::ccmks_blk_t o;
		o = '0;
		for (int i = 0; i < 16; i++) b[i] = ccmks_sbox(s[127-8*i -: 8]);
		for (int c = 0; c < 4; c++) begin
			for (int r = 0; r < 4; r++) t[r+4*c] = b[r+4*((c+r)%4)];
		end
		for (int c = 0; c < 4; c++) begin
			for (int r = 0; r < 4; r++) begin
				o[127-8*(4*c+r) -: 8] = last ? t[4*c+r] :
					ccmks_gmul(t[4*c+r], 8'h02) ^ ccmks_gmul(t[4*c+(r+1)%4], 8'h03) ^
					t[4*c+(r+2)%4] ^ t[4*c+(r+3)%4];
			end
		end
		return o;
	endfunction : ccmks_round

	function automatic ccmks_pkg::ccmks_blk_t ccmks_knext(input ccmks_pkg::ccmks_blk_t k,
		input logic [7:0] rc);
		logic [31:0] t;
		logic [31:0] w0;
		logic [31:0] w1;
		logic [31:0] w2;
		t = {ccmks_sbox(k[23:16]) ^ rc, ccmks_sbox(k[15:8]), ccmks_sbox(k[7:0]),
			ccmks_sbox(k[31:24])};
		w0 = k[127:96] ^ t;
		w1 = k[95:64] ^ w0;
		w2 = k[63:32] ^ w1;
		return {w0, w1, w2, k[31:0] ^ w2};
	endfunction : ccmks_knext

	ccmks_pkg::ccmks_blk_t st_q, st_d, rk_q, rk_d, nk;
	logic [7:0] rc_q, rc_d;
	logic [3:0] rnd_q, rnd_d;
	logic run_q, run_d, done_q, done_d;

	always_comb begin
		nk = ccmks_knext(rk_q, rc_q);
		st_d = st_q;
		rk_d = rk_q;
		rc_d = rc_q;
		rnd_d = rnd_q;
		run_d = run_q;
		done_d = 1'b0;
		if (aes.start) begin
			st_d = aes.din ^ aes.key;
			rk_d = aes.key;
			rc_d = 8'h01;
			rnd_d = 4'h1;
			run_d = 1'b1;
		end else if (run_q) begin
			// Ten rounds in ten clocks keeps a packet inside its air time
			st_d = ccmks_round(st_q, rnd_q == `CCMKS_AES_ROUNDS) ^ nk; // RULE17 RULE18
			rk_d = nk;
			rc_d = ccmks_gmul(rc_q, 8'h02);
			rnd_d = rnd_q + 4'h1;
			if (rnd_q == `CCMKS_AES_ROUNDS) begin
				run_d = 1'b0;
				done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= '0;
			rk_q <= '0;
			rc_q <= 8'h00;
			rnd_q <= 4'h0;
			run_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			st_q <= st_d;
			rk_q <= rk_d;
			rc_q <= rc_d;
			rnd_q <= rnd_d;
			run_q <= run_d;
			done_q <= done_d;
		end
	end

	assign aes.dout = st_q;
	assign aes.done = done_q;
endmodule : ccmks_aes

/* rtl/ccmks_aes_if.sv */
// Request and answer signals between the engine and its AES-128 core
`timescale 1ns/10ps
interface ccmks_aes_if;
	logic start;
	ccmks_pkg::ccmks_blk_t key;
	ccmks_pkg::ccmks_blk_t din;
	ccmks_pkg::ccmks_blk_t dout;
	logic done;
	modport core (input start, input key, input din, output dout, output done);
	modport eng (output start, output key, output din, input dout, input done);
endinterface : ccmks_aes_if

/* rtl/ccmks_defs.svh */
// Register map, field positions and constants of the CCM key-stream engine
`ifndef CCMKS_DEFS_SVH
`define CCMKS_DEFS_SVH
`define CCMKS_R_TASK 8'h00
`define CCMKS_R_EVENT 8'h04
`define CCMKS_R_MASK 8'h08
`define CCMKS_R_MODE 8'h0C
`define CCMKS_R_CFGPTR 8'h10
`define CCMKS_R_TMPPTR 8'h14
`define CCMKS_R_INPUT_PACKET_POINTER 8'h18
`define CCMKS_R_OUTPUT_PACKET_POINTER 8'h1C
`define CCMKS_R_MAXPL 8'h20
`define CCMKS_R_SHORT 8'h24
`define CCMKS_R_BUSY 8'h28
`define CCMKS_B_KS 0
`define CCMKS_B_CR 1
`define CCMKS_B_DEC 0
`define CCMKS_B_EXT 1
`define CCMKS_B_LW8 2
`define CCMKS_MODE_RST 3'h0
`define CCMKS_MAXPL_RST 8'hFB
`define CCMKS_KS_DEF 8'h1B
`define CCMKS_KS_MAX 8'hFB
`define CCMKS_MIC_LEN 8'h04
`define CCMKS_CFG_CTR 6'h10
`define CCMKS_CFG_CTR4 6'h14
`define CCMKS_CFG_DIR 6'h18
`define CCMKS_CFG_IV 6'h19
`define CCMKS_CFG_LAST 6'h20
`define CCMKS_HDR_LAST 6'h02
`define CCMKS_MIC_LAST 6'h03
`define CCMKS_BLK_LAST 6'h0F
`define CCMKS_PL_OFS 10'h003
`define CCMKS_KS_OFS 10'h010
`define CCMKS_FLAG_A 8'h01
`define CCMKS_FLAG_B0 8'h49
`define CCMKS_HDR_MASK 8'hE3
`define CCMKS_AES_ROUNDS 4'hA
`endif

/* rtl/ccmks_pkg.sv */
// Types shared by the CCM key-stream engine
package ccmks_pkg;
	typedef logic [127:0] ccmks_blk_t;
	typedef logic [103:0] ccmks_nonce_t;
	typedef enum logic [3:0] {
		CS_IDLE, CS_CFG_RD, CS_KS_RUN, CS_KS_WR, CS_HD_RD, CS_HD_WR,
		CS_S0_RD, CS_MAC_B0, CS_MAC_B1, CS_PL_MOV, CS_MAC_BLK, CS_MIC_WR
	} ccmks_state_e;
endpackage : ccmks_pkg

/* rtl/ccmks_top.sv */
// CCM key-stream generator and packet encryptor with byte memory master
// How it works
// RULE1: Fresh key-stream needed before every packet operation.
// RULE2: Key-stream task starts generation, raises done event.
// RULE3: Software sets pointer, config block, mode first.
// RULE4: Key-stream stored at temp area, reused later.
// RULE5: Default length gives 27 byte key-stream.
// RULE6: Extended length takes size from max payload.
// RULE7: Extended key-stream capped at 251 bytes.
// RULE8: Key-stream must cover next payload length.
// RULE9: Shortcut needs packet pointers set beforehand.
// RULE10: Read plain packet, encrypt, append check field.
// RULE11: Cipher task in encrypt mode runs, raises done.
// RULE12: Length plus four, packet written at output.
// RULE13: Zero length packet copied through unchanged.
// RULE14: Length field width chosen by mode.
// RULE15: XOR key-stream onto data, MAC same pass.
// RULE16: Memory master loads key, nonce, moves text.
// RULE17: Counter with CBC-MAC over AES-128.
// RULE18: Every operation fits in packet air time.
// RULE19: Tasks are pulses, events are sticky flags.
`timescale 1ns/10ps
`include "ccmks_defs.svh"
module ccmks_top (
	input logic clk,
	input logic sys_rst,
	input logic [7:0] reg_addr,
	input logic [31:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	output logic [31:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_rd,
	output logic mem_wr,
	input logic [7:0] mem_rdata,
	input logic mem_ack
);
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] ccmks_adr(input logic [31:0] b, input logic [9:0] o);
		return b + {22'h0, o};
	endfunction : ccmks_adr

	function automatic logic [7:0] ccmks_byte(input ccmks_pkg::ccmks_blk_t v,
		input logic [3:0] i);
		return v[127-8*i -: 8];
	endfunction : ccmks_byte

	////////////////////////////////////////////////////////////////////////////////
	ccmks_pkg::ccmks_state_e st_q, st_d;
	logic [5:0] idx_q, idx_d;
	logic [4:0] blk_q, blk_d;
	logic [7:0] pos_q, pos_d;
	logic [1:0] sub_q, sub_d;
	ccmks_pkg::ccmks_blk_t key_q, key_d, buf_q, buf_d, din_q, din_d, nb;
	ccmks_pkg::ccmks_nonce_t non_q, non_d;
	logic [7:0] hdr_q, hdr_d, len_q, len_d, rfu_q, rfu_d, pb_q, pb_d, ksb_q, ksb_d;
	logic [31:0] s0_q, s0_d;
	logic go_q, go_d;
	logic [31:0] madr_q, madr_d;
	logic [7:0] mwd_q, mwd_d;
	logic mrd_q, mrd_d, mwr_q, mwr_d, mbusy;
	logic ks_fin, cr_fin;
	logic [2:0] mode_q, mode_d;
	logic [1:0] ev_q, ev_d, mask_q, mask_d;
	logic [31:0] cfg_q, cfg_d, tmp_q, tmp_d, in_q, in_d, out_q, out_d;
	logic [7:0] maxpl_q, maxpl_d, kslen, plen, lenout;
	logic [4:0] nblk;
	logic sc_q, sc_d;
	logic [31:0] rdat_q, rdat_d;
	logic irq_q, irq_d;
	logic task_ks, task_cr;
	int j;

	ccmks_aes_if aes_bus ();
	ccmks_aes u_aes (
		.clk(clk),
		.sys_rst(sys_rst),
		.aes(aes_bus.core)
	);
	assign aes_bus.start = go_q;
	assign aes_bus.key = key_q;
	assign aes_bus.din = din_q;

	// Writes of one to the task register last exactly the write cycle
	assign task_ks = reg_wr && reg_addr == `CCMKS_R_TASK && reg_wdata[`CCMKS_B_KS]; // RULE19
	assign task_cr = reg_wr && reg_addr == `CCMKS_R_TASK && reg_wdata[`CCMKS_B_CR]; // RULE19
	assign mbusy = mrd_q || mwr_q;

	// Key-stream size and block count, S0 excluded
	assign kslen = !mode_q[`CCMKS_B_EXT] ? `CCMKS_KS_DEF : // RULE5
		(maxpl_q > `CCMKS_KS_MAX ? `CCMKS_KS_MAX : maxpl_q); // RULE6 RULE7
	assign nblk = 5'(({1'b0, kslen} + 9'h00F) >> 4);
	assign plen = mode_q[`CCMKS_B_LW8] ? len_q : {3'h0, len_q[4:0]}; // RULE14
	assign lenout = mode_q[`CCMKS_B_LW8] ? len_q + `CCMKS_MIC_LEN : // RULE12 RULE14
		{len_q[7:5], 5'(len_q[4:0] + `CCMKS_MIC_LEN)};

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		j = 0;
		st_d = st_q;
		idx_d = idx_q;
		blk_d = blk_q;
		pos_d = pos_q;
		sub_d = sub_q;
		key_d = key_q;
		buf_d = buf_q;
		din_d = din_q;
		non_d = non_q;
		hdr_d = hdr_q;
		len_d = len_q;
		rfu_d = rfu_q;
		pb_d = pb_q;
		ksb_d = ksb_q;
		s0_d = s0_q;
		go_d = 1'b0;
		madr_d = madr_q;
		mwd_d = mwd_q;
		mrd_d = mrd_q && !mem_ack;
		mwr_d = mwr_q && !mem_ack;
		ks_fin = 1'b0;
		cr_fin = 1'b0;
		nb = buf_q;
		nb[127-8*pos_q[3:0] -: 8] = pb_q;
		unique case (st_q)
			ccmks_pkg::CS_IDLE: begin
				idx_d = 6'h00;
				if (task_ks) st_d = ccmks_pkg::CS_CFG_RD; // RULE2
				else if (task_cr && !mode_q[`CCMKS_B_DEC]) st_d = ccmks_pkg::CS_HD_RD; // RULE11
			end
			ccmks_pkg::CS_CFG_RD: begin
				if (!mbusy) begin
					mrd_d = 1'b1;
					madr_d = ccmks_adr(cfg_q, {4'h0, idx_q}); // RULE16
				end else if (mem_ack) begin
					if (idx_q < `CCMKS_CFG_CTR) begin
						key_d[127-8*idx_q -: 8] = mem_rdata;
					end else if (idx_q < `CCMKS_CFG_CTR4) begin
						j = int'(idx_q) - 16;
						non_d[103-8*j -: 8] = mem_rdata;
					end else if (idx_q == `CCMKS_CFG_CTR4) begin
						non_d[71:64] = {1'b0, mem_rdata[6:0]};
					end else if (idx_q == `CCMKS_CFG_DIR) begin
						non_d[71] = mem_rdata[0];
					end else if (idx_q >= `CCMKS_CFG_IV) begin
						j = int'(idx_q) - 20;
						non_d[103-8*j -: 8] = mem_rdata;
					end
					idx_d = idx_q + 6'h01;
					if (idx_q == `CCMKS_CFG_LAST) begin
						blk_d = 5'h00;
						go_d = 1'b1;
						din_d = {`CCMKS_FLAG_A, non_d, 11'h000, 5'h00}; // RULE17
						st_d = ccmks_pkg::CS_KS_RUN;
					end
				end
			end
			ccmks_pkg::CS_KS_RUN: begin
				if (aes_bus.done) begin
					buf_d = aes_bus.dout;
					idx_d = 6'h00;
					st_d = ccmks_pkg::CS_KS_WR;
				end
			end
			ccmks_pkg::CS_KS_WR: begin
				if (!mbusy) begin
					mwr_d = 1'b1;
					madr_d = ccmks_adr(tmp_q, {1'b0, blk_q, idx_q[3:0]}); // RULE4
					mwd_d = ccmks_byte(buf_q, idx_q[3:0]);
				end else if (mem_ack) begin
					idx_d = idx_q + 6'h01;
					if (idx_q == `CCMKS_BLK_LAST) begin
						idx_d = 6'h00;
						if (blk_q == nblk) begin
							ks_fin = 1'b1; // RULE2
							// Pointers must already be valid when chained
							st_d = (sc_q && !mode_q[`CCMKS_B_DEC]) ? // RULE9
								ccmks_pkg::CS_HD_RD : ccmks_pkg::CS_IDLE;
						end else begin
							blk_d = blk_q + 5'h01;
							go_d = 1'b1;
							din_d = {`CCMKS_FLAG_A, non_q, 11'h000, blk_q + 5'h01};
							st_d = ccmks_pkg::CS_KS_RUN;
						end
					end
				end
			end
			ccmks_pkg::CS_HD_RD: begin
				if (!mbusy) begin
					mrd_d = 1'b1;
					madr_d = ccmks_adr(in_q, {4'h0, idx_q}); // RULE10
				end else if (mem_ack) begin
					idx_d = idx_q + 6'h01;
					if (idx_q == 6'h00) hdr_d = mem_rdata;
					if (idx_q == 6'h01) len_d = mem_rdata;
					if (idx_q == `CCMKS_HDR_LAST) begin
						rfu_d = mem_rdata;
						idx_d = 6'h00;
						st_d = ccmks_pkg::CS_HD_WR;
					end
				end
			end
			ccmks_pkg::CS_HD_WR: begin
				if (!mbusy) begin
					mwr_d = 1'b1;
					madr_d = ccmks_adr(out_q, {4'h0, idx_q}); // RULE12
					mwd_d = idx_q == 6'h00 ? hdr_q : idx_q == 6'h01 ?
						(plen == 8'h00 ? len_q : lenout) : rfu_q; // RULE13
				end else if (mem_ack) begin
					idx_d = idx_q + 6'h01;
					if (idx_q == `CCMKS_HDR_LAST) begin
						idx_d = 6'h00;
						if (plen == 8'h00) begin
							cr_fin = 1'b1; // RULE13
							st_d = ccmks_pkg::CS_IDLE;
						end else begin
							st_d = ccmks_pkg::CS_S0_RD;
						end
					end
				end
			end
			ccmks_pkg::CS_S0_RD: begin
				if (!mbusy) begin
					mrd_d = 1'b1;
					madr_d = ccmks_adr(tmp_q, {4'h0, idx_q}); // RULE4
				end else if (mem_ack) begin
					idx_d = idx_q + 6'h01;
					s0_d = {s0_q[23:0], mem_rdata};
					if (idx_q == `CCMKS_MIC_LAST) begin
						idx_d = 6'h00;
						go_d = 1'b1;
						din_d = {`CCMKS_FLAG_B0, non_q, 8'h00, plen}; // RULE17
						st_d = ccmks_pkg::CS_MAC_B0;
					end
				end
			end
			ccmks_pkg::CS_MAC_B0: begin
				if (aes_bus.done) begin
					go_d = 1'b1;
					din_d = aes_bus.dout ^ {8'h00, 8'h01, hdr_q & `CCMKS_HDR_MASK, 104'h0};
					st_d = ccmks_pkg::CS_MAC_B1;
				end
			end
			ccmks_pkg::CS_MAC_B1: begin
				if (aes_bus.done) begin
					pos_d = 8'h00;
					sub_d = 2'h0;
					buf_d = '0;
					st_d = ccmks_pkg::CS_PL_MOV;
				end
			end
			ccmks_pkg::CS_PL_MOV: begin
				if (!mbusy) begin
					mrd_d = sub_q != 2'h2;
					mwr_d = sub_q == 2'h2;
					madr_d = sub_q == 2'h1 ? ccmks_adr(tmp_q, `CCMKS_KS_OFS + {2'h0, pos_q}) :
						ccmks_adr(sub_q == 2'h0 ? in_q : out_q, `CCMKS_PL_OFS + {2'h0, pos_q});
					mwd_d = pb_q ^ ksb_q; // RULE15
				end else if (mem_ack) begin
					sub_d = sub_q + 2'h1;
					if (sub_q == 2'h0) pb_d = mem_rdata;
					if (sub_q == 2'h1) ksb_d = mem_rdata;
					if (sub_q == 2'h2) begin
						sub_d = 2'h0;
						buf_d = nb;
						pos_d = pos_q + 8'h01;
						// MAC chain advances per block; byte moves pause until that block's AES pass is done
						if (pos_q[3:0] == 4'hF || pos_q + 8'h01 == plen) begin
							go_d = 1'b1;
							din_d = aes_bus.dout ^ nb; // RULE15
							st_d = ccmks_pkg::CS_MAC_BLK;
						end
					end
				end
			end
			ccmks_pkg::CS_MAC_BLK: begin
				if (aes_bus.done) begin
					buf_d = '0;
					idx_d = 6'h00;
					st_d = pos_q == plen ? ccmks_pkg::CS_MIC_WR : ccmks_pkg::CS_PL_MOV;
				end
			end
			ccmks_pkg::CS_MIC_WR: begin
				if (!mbusy) begin
					mwr_d = 1'b1;
					madr_d = ccmks_adr(out_q, `CCMKS_PL_OFS + {2'h0, plen} + {4'h0, idx_q}); // RULE10
					mwd_d = ccmks_byte(aes_bus.dout, idx_q[3:0]) ^ s0_q[31-8*idx_q[1:0] -: 8];
				end else if (mem_ack) begin
					idx_d = idx_q + 6'h01;
					if (idx_q == `CCMKS_MIC_LAST) begin
						cr_fin = 1'b1; // RULE11
						st_d = ccmks_pkg::CS_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= ccmks_pkg::CS_IDLE;
			idx_q <= 6'h00;
			blk_q <= 5'h00;
			pos_q <= 8'h00;
			sub_q <= 2'h0;
			key_q <= '0;
			buf_q <= '0;
			din_q <= '0;
			non_q <= '0;
			hdr_q <= 8'h00;
			len_q <= 8'h00;
			rfu_q <= 8'h00;
			pb_q <= 8'h00;
			ksb_q <= 8'h00;
			s0_q <= 32'h0;
			go_q <= 1'b0;
			madr_q <= 32'h0;
			mwd_q <= 8'h00;
			mrd_q <= 1'b0;
			mwr_q <= 1'b0;
		end else begin
			st_q <= st_d;
			idx_q <= idx_d;
			blk_q <= blk_d;
			pos_q <= pos_d;
			sub_q <= sub_d;
			key_q <= key_d;
			buf_q <= buf_d;
			din_q <= din_d;
			non_q <= non_d;
			hdr_q <= hdr_d;
			len_q <= len_d;
			rfu_q <= rfu_d;
			pb_q <= pb_d;
			ksb_q <= ksb_d;
			s0_q <= s0_d;
			go_q <= go_d;
			madr_q <= madr_d;
			mwd_q <= mwd_d;
			mrd_q <= mrd_d;
			mwr_q <= mwr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		mode_d = mode_q;
		mask_d = mask_q;
		cfg_d = cfg_q;
		tmp_d = tmp_q;
		in_d = in_q;
		out_d = out_q;
		maxpl_d = maxpl_q;
		sc_d = sc_q;
		ev_d = ev_q;
		rdat_d = 32'h0;
		if (reg_wr) begin
			case (reg_addr)
				`CCMKS_R_EVENT: ev_d = ev_q & ~reg_wdata[1:0];
				`CCMKS_R_MASK: mask_d = reg_wdata[1:0];
				`CCMKS_R_MODE: mode_d = reg_wdata[2:0];
				`CCMKS_R_CFGPTR: cfg_d = reg_wdata;
				`CCMKS_R_TMPPTR: tmp_d = reg_wdata;
				`CCMKS_R_INPUT_PACKET_POINTER: in_d = reg_wdata;
				`CCMKS_R_OUTPUT_PACKET_POINTER: out_d = reg_wdata;
				`CCMKS_R_MAXPL: maxpl_d = reg_wdata[7:0];
				`CCMKS_R_SHORT: sc_d = reg_wdata[0];
				default: ;
			endcase
		end
		// Set wins over a clear in the same cycle
		ev_d = ev_d | {cr_fin, ks_fin}; // RULE19
		if (reg_rd) begin
			case (reg_addr)
				`CCMKS_R_EVENT: rdat_d = {30'h0, ev_q};
				`CCMKS_R_MASK: rdat_d = {30'h0, mask_q};
				`CCMKS_R_MODE: rdat_d = {29'h0, mode_q};
				`CCMKS_R_CFGPTR: rdat_d = cfg_q;
				`CCMKS_R_TMPPTR: rdat_d = tmp_q;
				`CCMKS_R_INPUT_PACKET_POINTER: rdat_d = in_q;
				`CCMKS_R_OUTPUT_PACKET_POINTER: rdat_d = out_q;
				`CCMKS_R_MAXPL: rdat_d = {24'h0, maxpl_q};
				`CCMKS_R_SHORT: rdat_d = {31'h0, sc_q};
				`CCMKS_R_BUSY: rdat_d = {31'h0, st_q != ccmks_pkg::CS_IDLE};
				default: rdat_d = 32'h0;
			endcase
		end
		irq_d = |(ev_d & mask_d);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_q <= `CCMKS_MODE_RST;
			mask_q <= 2'h0;
			cfg_q <= 32'h0;
			tmp_q <= 32'h0;
			in_q <= 32'h0;
			out_q <= 32'h0;
			maxpl_q <= `CCMKS_MAXPL_RST;
			sc_q <= 1'b0;
			ev_q <= 2'h0;
			rdat_q <= 32'h0;
			irq_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			mask_q <= mask_d;
			cfg_q <= cfg_d;
			tmp_q <= tmp_d;
			in_q <= in_d;
			out_q <= out_d;
			maxpl_q <= maxpl_d;
			sc_q <= sc_d;
			ev_q <= ev_d;
			rdat_q <= rdat_d;
			irq_q <= irq_d;
		end
	end

	assign reg_rdata = rdat_q;
	assign irq = irq_q;
	assign mem_addr = madr_q;
	assign mem_wdata = mwd_q;
	assign mem_rd = mrd_q;
	assign mem_wr = mwr_q;
endmodule : ccmks_top
